// ---- design/gp_consts.svh ----
// gp_consts.svh: register offsets, field positions, reset and key values
// of the shared GPIO port. Assumes byte addresses on an AXI4-Lite bus.
// Behaviour
// R01: An active peripheral drive disables the port driver; pin stays readable.
// R02: An enabled but idle peripheral leaves the pin to latch and direction.
// R03: Port output driving a pin never loops into the peripheral input.
// R04: Direction bit 1 makes the pin an input, 0 an output.
// R05: Reset sets every direction bit, so all pins start as inputs.
// R06: The latch register reads and writes the output latch.
// R07: Pin value reads return pins; writes to it land in the latch.
// R08: Unimplemented bits are disabled and read as zero; the analog config register stores and returns them unmasked.
// R09: Open-drain bit set: pin drives low only, released for high.
// R10: Analog config resets to zero: analog-capable pins start analog.
// R11: Pin value reads zero on bits configured as analog inputs.
// R12: Software keeps analog input pins set as inputs.
// R13: Software waits one cycle between a port write and a read.
// R14: Read-modify-write of the pin value register reads pins, not latch.
// R15: Enabled change-notify input changes request an interrupt, also in sleep.
// R16: Up to 31 change-notify inputs, count set by the device.
// R17: Each change-notify input has an enable bit across two registers.
// R18: Each change-notify pin has a pull-up enabled by one of two registers.
// R19: Software turns off pull-ups on pins used as digital outputs.
// R20: Remapping covers a fixed set of at most 26 pins.
// R21: Lock bit changes only after key bytes 0x46 then 0x57.
// R22: Map writes while locked complete normally but change nothing.
// R23: Any enabled input differing from its last sample sets a sticky flag.
`ifndef GP_CONSTS_SVH
`define GP_CONSTS_SVH
`define GP_DIR_OFS 8'h00
`define GP_LAT_OFS 8'h04
`define GP_PIN_OFS 8'h08
`define GP_ODC_OFS 8'h0c
`define GP_ANA_OFS 8'h10
`define GP_CNEN_LO_OFS 8'h14
`define GP_CNEN_HI_OFS 8'h18
`define GP_CNPU_LO_OFS 8'h1c
`define GP_CNPU_HI_OFS 8'h20
`define GP_STAT_OFS 8'h24
`define GP_OSC_OFS 8'h28
`define GP_MAP_OFS 8'h40
`define GP_LOCK_BIT 6
`define GP_FLAG_BIT 0
`define GP_ANA_RST 16'h0000
`define GP_LOCK_RST 1'b0
`define GP_KEY1 8'h46
`define GP_KEY2 8'h57
`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2
`endif

// ---- design/gp_pkg.sv ----
// gp_pkg: types shared by the shared GPIO port.
// Numeric constants live in gp_consts.svh.
package gp_pkg;
  typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} gp_unl_t;
endpackage

// ---- design/gp_axil_slave.sv ----
// gp_axil_slave: AXI4-Lite slave front end for the GPIO registers.
// Assumes a register file answering rd_data and errors combinationally.
`timescale 1ns/1ps
`include "gp_consts.svh"
module gp_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_ok_r, w_ok_r;

  // Both halves are held until the response is taken, so at most one
  // write is ever in flight.
  assign wr_en = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GP_RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en)
      begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `GP_RESP_SLVERR : `GP_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `GP_RESP_SLVERR : `GP_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // gp_axil_slave

// ---- design/gp_cn_detect.sv ----
// gp_cn_detect: change-of-state detector for the change-notify inputs.
// Assumes levels already synchronised to aclk.
`timescale 1ns/1ps
module gp_cn_detect #(
  parameter int CN_N = 31
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CN_N-1:0] lvl,
  input wire logic [CN_N-1:0] en,
  output logic chg
);
  logic [CN_N-1:0] prev_r;
  logic primed_r;

  // The first sample after reset only primes the history, so a pin that
  // idles high does not raise a spurious event.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_r <= '0;
      primed_r <= 1'b0;
      chg <= 1'b0;
    end
    else
    begin
      prev_r <= lvl;
      primed_r <= 1'b1;
      chg <= primed_r && ((lvl ^ prev_r) & en) != '0; // see R23
    end
  end
endmodule // gp_cn_detect

// ---- design/gp_port_top.sv ----
// gp_port_top: shared GPIO port with open drain, analog select, change
// notify with pull-up controls and a lockable pin remap table.
// Assumes peripheral enables and drives come from logic on aclk, and that
// aclk keeps running in sleep while the CPU clock is gated elsewhere.
`timescale 1ns/1ps
`include "gp_consts.svh"
module gp_port_top #(
  parameter logic [15:0] IMPL_MASK = 16'hffff,
  parameter logic [15:0] ANALOG_MASK = 16'h000f,
  parameter int CN_N = 31,
  parameter int MAP_N = 26
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pin_i,
  output logic [15:0] pin_o,
  output logic [15:0] pin_oe,
  input wire logic [15:0] periph_en,
  input wire logic [15:0] periph_oe,
  input wire logic [15:0] periph_out,
  output logic [15:0] periph_in,
  input wire logic [CN_N-1:0] cn_pin_i,
  output logic [CN_N-1:0] pullup_en,
  output logic cn_irq,
  output logic [5*MAP_N-1:0] map_o
);
  logic wr_en, wr_err, rd_err, cn_evt;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [15:0] dir_r, lat_r, odc_r, ana_r, pin_s1_r, pin_s2_r;
  logic [15:0] cnen_lo_r, cnen_hi_r, cnpu_lo_r, cnpu_hi_r;
  logic [15:0] drv, dat, ana_sel, pin_rd;
  logic [CN_N-1:0] cn_s1_r, cn_s2_r, cn_en;
  logic [31:0] cn_en_all, cn_pu_all;
  logic lock_r, cn_flag_r;
  gp_pkg::gp_unl_t unl_r;
  logic [4:0] map_r [MAP_N];

  function automatic logic [15:0] merge(logic [15:0] old, logic [31:0] d,
                                        logic [3:0] s);
    merge = old;
    if (s[0])
      merge[7:0] = d[7:0];
    if (s[1])
      merge[15:8] = d[15:8];
  endfunction

  function automatic logic is_map(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a >= `GP_MAP_OFS) &&
           (int'(a - `GP_MAP_OFS) < 4 * MAP_N);
  endfunction

  function automatic int map_idx(logic [7:0] a);
    return int'((a - `GP_MAP_OFS) >> 2);
  endfunction

  function automatic logic known(logic [7:0] a);
    case (a)
      `GP_DIR_OFS, `GP_LAT_OFS, `GP_PIN_OFS, `GP_ODC_OFS, `GP_ANA_OFS,
      `GP_CNEN_LO_OFS, `GP_CNEN_HI_OFS, `GP_CNPU_LO_OFS, `GP_CNPU_HI_OFS,
      `GP_STAT_OFS, `GP_OSC_OFS: known = 1'b1;
      default: known = is_map(a);
    endcase
  endfunction

  gp_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_err = !known(wr_addr);
  assign rd_err = !known(rd_addr);

  // Pins and change-notify inputs are asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
      cn_s1_r <= '0;
      cn_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      cn_s1_r <= cn_pin_i;
      cn_s2_r <= cn_s1_r;
    end
  end

  // Port configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_r <= IMPL_MASK; // see R05
      lat_r <= 16'h0000;
      odc_r <= 16'h0000;
      ana_r <= `GP_ANA_RST; // see R10
    end
    else if (wr_en)
    begin
      case (wr_addr)
        `GP_DIR_OFS: dir_r <= merge(dir_r, wr_data, wr_strb) & IMPL_MASK;
        `GP_LAT_OFS: lat_r <= merge(lat_r, wr_data, wr_strb) & IMPL_MASK;
        `GP_PIN_OFS: lat_r <= merge(lat_r, wr_data, wr_strb) & IMPL_MASK;
        `GP_ODC_OFS: odc_r <= merge(odc_r, wr_data, wr_strb) & IMPL_MASK;
        `GP_ANA_OFS: ana_r <= merge(ana_r, wr_data, wr_strb);
        default: ;
      endcase
    end
  end
  // Above: R06 on the latch write, R07 on the pin value write, R08 masks.

  // Change-notify enables and pull-ups
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnen_lo_r <= 16'h0000;
      cnen_hi_r <= 16'h0000;
      cnpu_lo_r <= 16'h0000;
      cnpu_hi_r <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        `GP_CNEN_LO_OFS: cnen_lo_r <= merge(cnen_lo_r, wr_data, wr_strb);
        `GP_CNEN_HI_OFS: cnen_hi_r <= merge(cnen_hi_r, wr_data, wr_strb);
        `GP_CNPU_LO_OFS: cnpu_lo_r <= merge(cnpu_lo_r, wr_data, wr_strb);
        `GP_CNPU_HI_OFS: cnpu_hi_r <= merge(cnpu_hi_r, wr_data, wr_strb);
        default: ;
      endcase
    end
  end

  assign cn_en_all = {cnen_hi_r, cnen_lo_r};
  assign cn_pu_all = {cnpu_hi_r, cnpu_lo_r};
  assign cn_en = cn_en_all[CN_N-1:0]; // see R16 R17
  assign pullup_en = cn_pu_all[CN_N-1:0]; // see R18

  gp_cn_detect #(.CN_N(CN_N)) u_cn (
    .aclk(aclk),
    .aresetn(aresetn),
    .lvl(cn_s2_r),
    .en(cn_en),
    .chg(cn_evt)
  );

  // Sticky change flag; a new event beats a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cn_flag_r <= 1'b0;
    else if (cn_evt)
      cn_flag_r <= 1'b1; // see R15 R23
    else if (wr_en && wr_addr == `GP_STAT_OFS && wr_strb[0] &&
             wr_data[`GP_FLAG_BIT])
      cn_flag_r <= 1'b0;
  end
  assign cn_irq = cn_flag_r;

  // Remap lock: key bytes must come as back-to-back writes to the low byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unl_r <= gp_pkg::UNL_IDLE;
      lock_r <= `GP_LOCK_RST;
    end
    else if (wr_en)
    begin
      if (wr_addr == `GP_OSC_OFS && wr_strb[0])
      begin
        case (unl_r)
          gp_pkg::UNL_IDLE:
            unl_r <= (wr_data[7:0] == `GP_KEY1) ? gp_pkg::UNL_KEY1
                                                : gp_pkg::UNL_IDLE;
          gp_pkg::UNL_KEY1:
            if (wr_data[7:0] == `GP_KEY2)
              unl_r <= gp_pkg::UNL_OPEN; // see R21
            else if (wr_data[7:0] != `GP_KEY1)
              unl_r <= gp_pkg::UNL_IDLE;
          gp_pkg::UNL_OPEN:
          begin
            lock_r <= wr_data[`GP_LOCK_BIT]; // see R21
            unl_r <= gp_pkg::UNL_IDLE;
          end
          default: unl_r <= gp_pkg::UNL_IDLE;
        endcase
      end
      else
        unl_r <= gp_pkg::UNL_IDLE;
    end
  end

  // Remap table; locked writes still answer OKAY
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < MAP_N; i++)
        map_r[i] <= 5'h00;
    end
    else if (wr_en && !lock_r && is_map(wr_addr) && wr_strb[0])
      map_r[map_idx(wr_addr)] <= wr_data[4:0]; // see R20 R22
  end

  always_comb
  begin
    for (int i = 0; i < MAP_N; i++)
      map_o[i*5 +: 5] = map_r[i];
  end

  // Pin ownership and drive
  assign drv = periph_en & periph_oe; // see R01 R02
  assign dat = (drv & periph_out) | (~drv & lat_r);
  assign ana_sel = ANALOG_MASK & ~ana_r; // see R10
  assign pin_rd = pin_s2_r & IMPL_MASK & ~ana_sel; // see R08 R11 R14

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_o <= 16'h0000;
      pin_oe <= 16'h0000;
      periph_in <= 16'h0000;
    end
    else
    begin
      pin_o <= dat & ~odc_r & IMPL_MASK; // see R09
      // Driven when a peripheral owns it or the port bit is an output, except an open-drain bit whose data is high
      pin_oe <= (drv | ~dir_r) & (~odc_r | ~dat) & IMPL_MASK; // see R04 R09
      // Port-driven pins are hidden from peripheral inputs
      periph_in <= pin_s2_r & (drv | dir_r) & ~ana_sel; // see R03
    end
  end

  // Register read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `GP_DIR_OFS: rd_data[15:0] = dir_r;
      `GP_LAT_OFS: rd_data[15:0] = lat_r; // see R06
      `GP_PIN_OFS: rd_data[15:0] = pin_rd; // see R07 R14
      `GP_ODC_OFS: rd_data[15:0] = odc_r;
      `GP_ANA_OFS: rd_data[15:0] = ana_r;
      `GP_CNEN_LO_OFS: rd_data[15:0] = cnen_lo_r;
      `GP_CNEN_HI_OFS: rd_data[15:0] = cnen_hi_r;
      `GP_CNPU_LO_OFS: rd_data[15:0] = cnpu_lo_r;
      `GP_CNPU_HI_OFS: rd_data[15:0] = cnpu_hi_r;
      `GP_STAT_OFS: rd_data[`GP_FLAG_BIT] = cn_flag_r;
      `GP_OSC_OFS: rd_data[`GP_LOCK_BIT] = lock_r;
      default:
        if (is_map(rd_addr))
          rd_data[4:0] = map_r[map_idx(rd_addr)];
    endcase
  end

  sequence key1_s;
    wr_en && wr_addr == `GP_OSC_OFS && wr_strb[0] &&
    wr_data[7:0] == `GP_KEY1;
  endsequence

  sequence key2_s;
    wr_en && wr_addr == `GP_OSC_OFS && wr_strb[0] &&
    wr_data[7:0] == `GP_KEY2;
  endsequence

  dir_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R05
    $past(!aresetn) |-> dir_r == IMPL_MASK && ana_r == `GP_ANA_RST)
    else $error("direction or analog config wrong after reset");

  periph_own_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R01
    $past(drv[0] && !odc_r[0]) && IMPL_MASK[0]
    |-> pin_oe[0] && pin_o[0] == $past(periph_out[0]))
    else $error("peripheral drive not on pin 0");

  port_own_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R02
    $past(!drv[0] && !dir_r[0] && !odc_r[0]) && IMPL_MASK[0]
    |-> pin_oe[0] && pin_o[0] == $past(lat_r[0]))
    else $error("port latch not on pin 0");

  no_loop_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R03
    $past(!drv[0] && !dir_r[0]) |-> !periph_in[0])
    else $error("port output looped into peripheral input");

  odrain_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R09
    $past(odc_r) != 16'h0000
    |-> (pin_oe & (pin_o | $past(dat)) & $past(odc_r)) == 16'h0000)
    else $error("open-drain pin driven high");

  analog_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `GP_PIN_OFS
    |=> (s_axi_rdata[15:0] & $past(ana_sel)) == 16'h0000 && s_axi_rvalid)
    else $error("analog pin read as nonzero");

  pin_to_lat_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R07
    wr_en && wr_addr == `GP_PIN_OFS && wr_strb[1:0] == 2'h3
    |=> lat_r == ($past(wr_data[15:0]) & IMPL_MASK))
    else $error("pin value write missed the latch");

  key_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R21
    unl_r == gp_pkg::UNL_KEY1 and key2_s |=> unl_r == gp_pkg::UNL_OPEN)
    else $error("second key did not open the lock");

  key_first_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R21
    key1_s and unl_r != gp_pkg::UNL_OPEN |=> unl_r == gp_pkg::UNL_KEY1)
    else $error("first key not recorded");

  lock_guard_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R21
    !$stable(lock_r) |-> $past(unl_r) == gp_pkg::UNL_OPEN)
    else $error("lock bit changed without unlock");

  map_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R22
    lock_r && wr_en && wr_addr == `GP_MAP_OFS |=> $stable(map_r[0]))
    else $error("locked map entry changed");

  cn_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R23
    cn_evt |=> cn_flag_r && cn_irq)
    else $error("change event lost");
endmodule // gp_port_top

// ---- tb/gp_pin_model.sv ----
// gp_pin_model: pads and board wiring seen by the shared port.
// Assumes the bench sets the board level of every pin the port releases.
`timescale 1ns/1ps
module gp_pin_model (
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_lvl,
  output logic [15:0] pin_i
);
  // A released pin shows the board level, never the last driven value
  assign pin_i = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // gp_pin_model

// ---- tb/tb.sv ----
// tb: register-level tests of the shared GPIO port over AXI4-Lite.
// Assumes the pin model closes the pad loop and one write/read at a time.
`timescale 1ns/1ps
`include "gp_consts.svh"
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  // Bit 15 left out so unimplemented bits are exercised
  localparam logic [15:0] IMPL = 16'h7fff;
  localparam logic [1:0] OK = `GP_RESP_OKAY;
  localparam logic [1:0] ERR = `GP_RESP_SLVERR;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] pin_i, pin_o, pin_oe, ext_lvl;
  logic [15:0] periph_en, periph_oe, periph_out, periph_in;
  logic [30:0] cn_pin_i, pullup_en;
  logic cn_irq;
  logic [129:0] map_o;
  int failures, samples_checked;

  gp_port_top #(.IMPL_MASK(IMPL)) i_gp_port_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .periph_en(periph_en), .periph_oe(periph_oe),
    .periph_out(periph_out), .periph_in(periph_in),
    .cn_pin_i(cn_pin_i), .pullup_en(pullup_en), .cn_irq(cn_irq),
    .map_o(map_o)
  );

  gp_pin_model i_gp_pin_model (
    .pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK($sformatf("bresp %h", a), er, bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK($sformatf("rdata %h", a), {16'h0000, e}, rdata)
    `CHK($sformatf("rresp %h", a), er, rresp)
  endtask

  // Software gap after a port write, longer than the pad sync path
  task automatic gap;
    repeat (6) @(posedge aclk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    test_done;
  end

  initial
  begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    ext_lvl = 16'hffff;
    periph_en = 16'h0000;
    periph_oe = 16'h0000;
    periph_out = 16'h0000;
    cn_pin_i = 31'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`GP_DIR_OFS, IMPL, OK);
    rd(`GP_ANA_OFS, `GP_ANA_RST, OK);
    rd(`GP_PIN_OFS, IMPL & 16'hfff0, OK);
    `CHK("pin_oe", 16'h0000, pin_oe)
    wr(`GP_ANA_OFS, 16'hffff, OK);
    wr(`GP_LAT_OFS, 16'hffa5, OK);
    rd(`GP_LAT_OFS, IMPL & 16'hffa5, OK);
    wr(`GP_DIR_OFS, 16'h0000, OK);
    gap;
    `CHK("pin_oe", IMPL, pin_oe)
    `CHK("pin_o", 16'h7fa5, pin_o & IMPL)
    `CHK("periph_in", 16'h0000, periph_in)
    rd(`GP_PIN_OFS, 16'h7fa5, OK);
    wr(`GP_PIN_OFS, 16'h1234, OK);
    rd(`GP_LAT_OFS, 16'h1234, OK);
    // Open drain with a low board level: pin reads differ from latch
    wr(`GP_ODC_OFS, 16'hffff, OK);
    ext_lvl <= 16'h0000;
    gap;
    `CHK("pin_oe", ~16'h1234 & IMPL, pin_oe)
    rd(`GP_PIN_OFS, 16'h0000, OK);
    wr(`GP_ODC_OFS, 16'h0000, OK);
    wr(`GP_LAT_OFS, 16'h00a5, OK);
    periph_en <= 16'h00f0;
    periph_oe <= 16'h0030;
    periph_out <= 16'h0010;
    gap;
    `CHK("pin_o", 16'h0095, pin_o & IMPL)
    `CHK("pin_oe", IMPL, pin_oe)
    wr(`GP_DIR_OFS, 16'hff00, OK);
    ext_lvl <= 16'hab00;
    gap;
    `CHK("pin_oe", 16'h00ff, pin_oe)
    `CHK("periph_in", 16'h2b00, periph_in & 16'h7fcf)
    periph_en <= 16'h0000;
    periph_oe <= 16'h0000;
    // Pull-ups only on change-notify inputs, none used as outputs
    wr(`GP_CNPU_LO_OFS, 16'h0003, OK);
    wr(`GP_CNPU_HI_OFS, 16'h0001, OK);
    `CHK("pullup_en", 31'h0001_0003, pullup_en)
    wr(`GP_CNEN_LO_OFS, 16'h0001, OK);
    wr(`GP_CNEN_HI_OFS, 16'h4010, OK);
    gap;
    cn_pin_i <= 31'h0000_0002;
    repeat (8) @(posedge aclk);
    `CHK("cn_irq", 1'b0, cn_irq)
    cn_pin_i <= 31'h0000_0003;
    repeat (8) @(posedge aclk);
    `CHK("cn_irq", 1'b1, cn_irq)
    rd(`GP_STAT_OFS, 16'h0001, OK);
    wr(`GP_STAT_OFS, 16'h0001, OK);
    `CHK("cn_irq", 1'b0, cn_irq)
    cn_pin_i <= 31'h0010_0003;
    repeat (8) @(posedge aclk);
    `CHK("cn_irq", 1'b1, cn_irq)
    wr(`GP_STAT_OFS, 16'h0001, OK);
    cn_pin_i <= 31'h4010_0003;
    repeat (8) @(posedge aclk);
    `CHK("cn_irq", 1'b1, cn_irq)
    // Remap table: lock, refused sequences, unlock
    wr(`GP_MAP_OFS, 16'h0003, OK);
    rd(`GP_MAP_OFS, 16'h0003, OK);
    wr(`GP_OSC_OFS, {8'h00, `GP_KEY1}, OK);
    wr(`GP_OSC_OFS, {8'h00, `GP_KEY2}, OK);
    wr(`GP_OSC_OFS, 16'h0040, OK);
    wr(`GP_MAP_OFS, 16'h0007, OK);
    rd(`GP_MAP_OFS, 16'h0003, OK);
    `CHK("map_o", 5'h03, map_o[4:0])
    wr(`GP_OSC_OFS, 16'h0000, OK);
    wr(`GP_OSC_OFS, {8'h00, `GP_KEY1}, OK);
    wr(`GP_LAT_OFS, 16'h0000, OK);
    wr(`GP_OSC_OFS, {8'h00, `GP_KEY2}, OK);
    wr(`GP_OSC_OFS, 16'h0000, OK);
    wr(`GP_MAP_OFS, 16'h0007, OK);
    rd(`GP_MAP_OFS, 16'h0003, OK);
    wr(`GP_OSC_OFS, {8'h00, `GP_KEY1}, OK);
    wr(`GP_OSC_OFS, {8'h00, `GP_KEY2}, OK);
    wr(`GP_OSC_OFS, 16'h0000, OK);
    wr(`GP_MAP_OFS + 8'd100, 16'h001f, OK);
    rd(`GP_MAP_OFS + 8'd100, 16'h001f, OK);
    `CHK("map_o", 5'h1f, map_o[129:125])
    wr(`GP_MAP_OFS + 8'd104, 16'h0001, ERR);
    rd(8'h3c, 16'h0000, ERR);
    test_done;
  end
endmodule // tb
